//--- rtl/slis_consts.vh
// constants of the second-level event status block: offsets, bit positions,
// layouts and reset values; included by the status block and its group cell
`ifndef SLIS_CONSTS_VH
`define SLIS_CONSTS_VH

// register offsets on the plain register port
`define SLIS_AUD_STATUS_OFF    32'h0B000084
`define SLIS_KEY_STATUS_OFF    32'h0B000086
`define SLIS_PIN_STATUS_OFF    32'h0B000088
`define SLIS_DBG_STATUS_OFF    32'h0B00008A
`define SLIS_AUD_MASK_OFF      32'h0B000090
`define SLIS_KEY_MASK_OFF      32'h0B000092
`define SLIS_PIN_MASK_OFF      32'h0B000094
`define SLIS_DBG_MASK_OFF      32'h0B000096

// audio status field positions
`define SLIS_MIC_PAGE2_BIT     4'hB
`define SLIS_MIC_PAGE1_BIT     4'hA
`define SLIS_MIC_OVERRUN_BIT   4'h9
`define SLIS_MIC_RX_DONE_BIT   4'h8
`define SLIS_SPK_PAGE2_BIT     4'h3
`define SLIS_SPK_PAGE1_BIT     4'h2
`define SLIS_SPK_UNDERRUN_BIT  4'h1

// keyboard status field positions
`define SLIS_KEY_LOST_BIT      4'h2
`define SLIS_KEY_DONE_BIT      4'h1
`define SLIS_KEY_PRESS_BIT     4'h0

// debug serial status field positions
`define SLIS_DBG_CTS_BIT       4'hB
`define SLIS_DBG_RX_ERR_BIT    4'hA
`define SLIS_DBG_RX_DONE_BIT   4'h9
`define SLIS_DBG_TX_DONE_BIT   4'h8

// implemented flag positions of each word; all others read zero except debug bit 0
`define SLIS_AUD_FLAG_BITS     16'h0F0E
`define SLIS_KEY_FLAG_BITS     16'h0007
`define SLIS_PIN_FLAG_BITS     16'hFFFF
`define SLIS_DBG_FLAG_BITS     16'h0F00

// positions that always read one
`define SLIS_NO_FIXED_ONES     16'h0000
`define SLIS_DBG_FIXED_ONES    16'h0001

// reset values
`define SLIS_STATUS_RST        16'h0000
`define SLIS_DBG_STATUS_RST    16'h0001
`define SLIS_MASK_RST          16'h0000
`define SLIS_READ_RST          16'h0000
`define SLIS_CTS_N_RST         1'h1

`endif

//--- rtl/slis_group.v
// one second-level status word: sticky event flags, fixed bits, group request
// assumes set and clear vectors come from logic on the same clock
`timescale 1ns/1ps
`include "slis_consts.vh"

module slis_group #(
    parameter [15:0] FLAG_BITS  = 16'hFFFF,
    parameter [15:0] FIXED_ONES = 16'h0000
) (
    input  wire        clk,
    input  wire        rst,
    input  wire [15:0] set_vec,
    input  wire [15:0] clr_vec,
    input  wire [15:0] mask_vec,
    output reg  [15:0] status_reg,
    output reg         summary_reg
);

    reg [15:0] status_next;
    reg        summary_next;

    ////////////////////////////////////////////////////////////////////////
    always @* begin
        // set beats a clear in the same cycle, so no event is lost
        status_next  = (((status_reg & ~clr_vec) | set_vec) & FLAG_BITS) | FIXED_ONES;
        // request only for a flag that is set and enabled
        summary_next = |(status_next & mask_vec & FLAG_BITS);
    end

    always @(posedge clk) begin
        if (rst) begin
            status_reg  <= FIXED_ONES;
            summary_reg <= 1'h0;
        end else begin
            status_reg  <= status_next;
            summary_reg <= summary_next;
        end
    end

endmodule // slis_group

//--- rtl/slis_status.v
// second-level event status words for audio, keyboard, pin and debug serial
// units, with their mask words and the group requests to the first level
// assumes event strobes are one-cycle pulses from logic on CLOCK; the
// clear-to-send pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "slis_consts.vh"

module slis_status (
    input  wire        CLOCK,
    input  wire        RST,
    input  wire        RTC_RST,
    input  wire [31:0] ADDRESS,
    input  wire [15:0] WRITE_DATA,
    input  wire        WRITE_STROBE,
    input  wire        READ_STROBE,
    output reg  [15:0] READ_DATA,
    input  wire        MIC_PAGE2_EVENT,
    input  wire        MIC_PAGE1_EVENT,
    input  wire        MIC_SAMPLE_STROBE,
    input  wire        MIC_HOLDING_VALID,
    input  wire        SPK_PAGE2_EVENT,
    input  wire        SPK_PAGE1_EVENT,
    input  wire        SPK_DA_XFER_STROBE,
    input  wire        SPK_HOLDING_VALID,
    input  wire [15:0] AUDIO_CLEAR,
    input  wire        KEY_SCAN_LOST_EVENT,
    input  wire        KEY_SCAN_DONE_EVENT,
    input  wire        KEY_PRESS_EVENT,
    input  wire [15:0] KEYBOARD_CLEAR,
    input  wire [15:0] PIN_EVENTS,
    input  wire [15:0] PIN_CLEAR,
    input  wire        DEBUG_CLEAR_TO_SEND_N,
    input  wire        DBG_RX_ERROR_EVENT,
    input  wire        DBG_RX_DONE_EVENT,
    input  wire        DBG_TX_DONE_EVENT,
    input  wire [15:0] DEBUG_CLEAR,
    output wire        AUDIO_GROUP_SUMMARY,
    output wire        KEYBOARD_GROUP_SUMMARY,
    output wire        PIN_GROUP_SUMMARY,
    output wire        DEBUG_GROUP_SUMMARY,
    output wire [15:0] AUDIO_EVENT_STATUS,
    output wire [15:0] KEYBOARD_EVENT_STATUS,
    output wire [15:0] PIN_EVENT_STATUS_LOW,
    output wire [15:0] DEBUG_SERIAL_EVENT_STATUS
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // one flag placed at its field position
    function [15:0] slis_bit;
        input       value;
        input [3:0] pos;
        begin
            slis_bit = {15'h0000, value} << pos;
        end
    endfunction

    // full-address match against one register offset
    function slis_hit;
        input [31:0] addr;
        input [31:0] offset;
        begin
            slis_hit = (addr == offset);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // declarations

    wire        any_rst;
    wire [15:0] audio_event_status;
    wire [15:0] keyboard_event_status;
    wire [15:0] pin_event_status_low;
    wire [15:0] debug_serial_event_status;
    wire        audio_summary;
    wire        keyboard_summary;
    wire        pin_summary;
    wire        debug_summary;
    wire        aud_mask_wr;
    wire        key_mask_wr;
    wire        pin_mask_wr;
    wire        dbg_mask_wr;

    reg  [15:0] audio_event_mask_reg;
    reg  [15:0] audio_event_mask_next;
    reg  [15:0] keyboard_event_mask_reg;
    reg  [15:0] keyboard_event_mask_next;
    reg  [15:0] pin_event_mask_reg;
    reg  [15:0] pin_event_mask_next;
    reg  [15:0] debug_event_mask_reg;
    reg  [15:0] debug_event_mask_next;
    reg  [15:0] read_data_next;

    reg         cts_s1_reg;
    reg         cts_s2_reg;
    reg         cts_s3_reg;
    reg         cts_level_reg;
    reg         cts_level_next;
    reg         cts_change;

    reg  [15:0] audio_set;
    reg  [15:0] keyboard_set;
    reg  [15:0] pin_set;
    reg  [15:0] debug_set;

    // the timer-domain reset clears the flags just like the system reset
    assign any_rst = RST | RTC_RST;

    // mask write decode; the full address is compared, so no alias ever hits
    assign aud_mask_wr = WRITE_STROBE & slis_hit(ADDRESS, `SLIS_AUD_MASK_OFF);
    assign key_mask_wr = WRITE_STROBE & slis_hit(ADDRESS, `SLIS_KEY_MASK_OFF);
    assign pin_mask_wr = WRITE_STROBE & slis_hit(ADDRESS, `SLIS_PIN_MASK_OFF);
    assign dbg_mask_wr = WRITE_STROBE & slis_hit(ADDRESS, `SLIS_DBG_MASK_OFF);

    ////////////////////////////////////////////////////////////////////////
    // clear-to-send pin: three stages, change accepted once the last two stages agree
    // costs a few cycles before bit 11 shows; the pin is slow, so that is cheap

    always @(posedge CLOCK) begin
        if (any_rst) begin
            cts_s1_reg    <= `SLIS_CTS_N_RST;
            cts_s2_reg    <= `SLIS_CTS_N_RST;
            cts_s3_reg    <= `SLIS_CTS_N_RST;
            cts_level_reg <= `SLIS_CTS_N_RST;
        end else begin
            cts_s1_reg    <= DEBUG_CLEAR_TO_SEND_N;
            cts_s2_reg    <= cts_s1_reg;
            cts_s3_reg    <= cts_s2_reg;
            cts_level_reg <= cts_level_next;
        end
    end

    always @* begin
        cts_level_next = cts_level_reg;
        cts_change     = 1'h0;
        // first stage is never looked at; glitches shorter than a cycle drop out
        if ((cts_s2_reg == cts_s3_reg) && (cts_s3_reg != cts_level_reg)) begin
            cts_level_next = cts_s3_reg;
            cts_change     = 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event set vectors
    // one late sample sets overrun and receive-done together: both are true

    always @* begin
        audio_set = slis_bit(MIC_PAGE2_EVENT, `SLIS_MIC_PAGE2_BIT)
                  | slis_bit(MIC_PAGE1_EVENT, `SLIS_MIC_PAGE1_BIT)
                  | slis_bit(MIC_SAMPLE_STROBE & MIC_HOLDING_VALID,
                             `SLIS_MIC_OVERRUN_BIT)
                  | slis_bit(MIC_SAMPLE_STROBE, `SLIS_MIC_RX_DONE_BIT)
                  | slis_bit(SPK_PAGE2_EVENT, `SLIS_SPK_PAGE2_BIT)
                  | slis_bit(SPK_PAGE1_EVENT, `SLIS_SPK_PAGE1_BIT)
                  | slis_bit(SPK_DA_XFER_STROBE & ~SPK_HOLDING_VALID,
                             `SLIS_SPK_UNDERRUN_BIT);
    end

    always @* begin
        keyboard_set = slis_bit(KEY_SCAN_LOST_EVENT, `SLIS_KEY_LOST_BIT)
                     | slis_bit(KEY_SCAN_DONE_EVENT, `SLIS_KEY_DONE_BIT)
                     | slis_bit(KEY_PRESS_EVENT, `SLIS_KEY_PRESS_BIT);
    end

    always @* begin
        pin_set = PIN_EVENTS;
    end

    always @* begin
        debug_set = slis_bit(cts_change, `SLIS_DBG_CTS_BIT)
                  | slis_bit(DBG_RX_ERROR_EVENT, `SLIS_DBG_RX_ERR_BIT)
                  | slis_bit(DBG_RX_DONE_EVENT, `SLIS_DBG_RX_DONE_BIT)
                  | slis_bit(DBG_TX_DONE_EVENT, `SLIS_DBG_TX_DONE_BIT);
    end

    ////////////////////////////////////////////////////////////////////////
    // the four status words
    // debug word bit 0 is held at one inside its cell, through every reset

    slis_group #(
        .FLAG_BITS  (`SLIS_AUD_FLAG_BITS),
        .FIXED_ONES (`SLIS_NO_FIXED_ONES)
    ) u_audio (
        .clk         (CLOCK),
        .rst         (any_rst),
        .set_vec     (audio_set),
        .clr_vec     (AUDIO_CLEAR),
        .mask_vec    (audio_event_mask_reg),
        .status_reg  (audio_event_status),
        .summary_reg (audio_summary)
    );

    slis_group #(
        .FLAG_BITS  (`SLIS_KEY_FLAG_BITS),
        .FIXED_ONES (`SLIS_NO_FIXED_ONES)
    ) u_keyboard (
        .clk         (CLOCK),
        .rst         (any_rst),
        .set_vec     (keyboard_set),
        .clr_vec     (KEYBOARD_CLEAR),
        .mask_vec    (keyboard_event_mask_reg),
        .status_reg  (keyboard_event_status),
        .summary_reg (keyboard_summary)
    );

    slis_group #(
        .FLAG_BITS  (`SLIS_PIN_FLAG_BITS),
        .FIXED_ONES (`SLIS_NO_FIXED_ONES)
    ) u_pin (
        .clk         (CLOCK),
        .rst         (any_rst),
        .set_vec     (pin_set),
        .clr_vec     (PIN_CLEAR),
        .mask_vec    (pin_event_mask_reg),
        .status_reg  (pin_event_status_low),
        .summary_reg (pin_summary)
    );

    slis_group #(
        .FLAG_BITS  (`SLIS_DBG_FLAG_BITS),
        .FIXED_ONES (`SLIS_DBG_FIXED_ONES)
    ) u_debug (
        .clk         (CLOCK),
        .rst         (any_rst),
        .set_vec     (debug_set),
        .clr_vec     (DEBUG_CLEAR),
        .mask_vec    (debug_event_mask_reg),
        .status_reg  (debug_serial_event_status),
        .summary_reg (debug_summary)
    );

    // all straight from flip-flops inside the group cells
    assign AUDIO_GROUP_SUMMARY       = audio_summary;
    assign KEYBOARD_GROUP_SUMMARY    = keyboard_summary;
    assign PIN_GROUP_SUMMARY         = pin_summary;
    assign DEBUG_GROUP_SUMMARY       = debug_summary;
    assign AUDIO_EVENT_STATUS        = audio_event_status;
    assign KEYBOARD_EVENT_STATUS     = keyboard_event_status;
    assign PIN_EVENT_STATUS_LOW      = pin_event_status_low;
    assign DEBUG_SERIAL_EVENT_STATUS = debug_serial_event_status;

    ////////////////////////////////////////////////////////////////////////
    // mask words: writable only at implemented positions

    always @* begin
        audio_event_mask_next    = audio_event_mask_reg;
        keyboard_event_mask_next = keyboard_event_mask_reg;
        pin_event_mask_next      = pin_event_mask_reg;
        debug_event_mask_next    = debug_event_mask_reg;
        // status words are read-only, a write to them changes nothing
        // reserved positions forced to zero so a stray one never enables a request
        if (aud_mask_wr) begin
            audio_event_mask_next = WRITE_DATA & `SLIS_AUD_FLAG_BITS;
        end
        if (key_mask_wr) begin
            keyboard_event_mask_next = WRITE_DATA & `SLIS_KEY_FLAG_BITS;
        end
        if (pin_mask_wr) begin
            pin_event_mask_next = WRITE_DATA & `SLIS_PIN_FLAG_BITS;
        end
        if (dbg_mask_wr) begin
            debug_event_mask_next = WRITE_DATA & `SLIS_DBG_FLAG_BITS;
        end
    end

    always @(posedge CLOCK) begin
        if (any_rst) begin
            audio_event_mask_reg    <= `SLIS_MASK_RST;
            keyboard_event_mask_reg <= `SLIS_MASK_RST;
            pin_event_mask_reg      <= `SLIS_MASK_RST;
            debug_event_mask_reg    <= `SLIS_MASK_RST;
        end else begin
            audio_event_mask_reg    <= audio_event_mask_next;
            keyboard_event_mask_reg <= keyboard_event_mask_next;
            pin_event_mask_reg      <= pin_event_mask_next;
            debug_event_mask_reg    <= debug_event_mask_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data stands only in the cycle after the strobe
    // reading has no side effect; flags clear only by clear vectors or reset

    always @* begin
        read_data_next = `SLIS_READ_RST;
        if (READ_STROBE) begin
            case (ADDRESS)
                `SLIS_AUD_STATUS_OFF: begin
                    read_data_next = audio_event_status;
                end
                `SLIS_KEY_STATUS_OFF: begin
                    read_data_next = keyboard_event_status;
                end
                `SLIS_PIN_STATUS_OFF: begin
                    read_data_next = pin_event_status_low;
                end
                `SLIS_DBG_STATUS_OFF: begin
                    read_data_next = debug_serial_event_status;
                end
                `SLIS_AUD_MASK_OFF: begin
                    read_data_next = audio_event_mask_reg;
                end
                `SLIS_KEY_MASK_OFF: begin
                    read_data_next = keyboard_event_mask_reg;
                end
                `SLIS_PIN_MASK_OFF: begin
                    read_data_next = pin_event_mask_reg;
                end
                `SLIS_DBG_MASK_OFF: begin
                    read_data_next = debug_event_mask_reg;
                end
                default: begin
                    // unmapped addresses answer zero
                    read_data_next = `SLIS_READ_RST;
                end
            endcase
        end
    end

    always @(posedge CLOCK) begin
        if (any_rst) begin
            READ_DATA <= `SLIS_READ_RST;
        end else begin
            // zero outside the answer cycle, so a shared read bus sees no stale word
            READ_DATA <= read_data_next;
        end
    end

endmodule // slis_status

//--- verification/slis_checker.sv
// assertions on the ports of the event status block
// assumes one clock; either reset input clears the block
`timescale 1ns/1ps
`include "slis_consts.vh"

module slis_checker (
    input wire        CLOCK,
    input wire        RST,
    input wire        RTC_RST,
    input wire [31:0] ADDRESS,
    input wire        READ_STROBE,
    input wire [15:0] READ_DATA,
    input wire        MIC_SAMPLE_STROBE,
    input wire        MIC_HOLDING_VALID,
    input wire        SPK_DA_XFER_STROBE,
    input wire        SPK_HOLDING_VALID,
    input wire [15:0] PIN_EVENTS,
    input wire        PIN_GROUP_SUMMARY,
    input wire [15:0] AUDIO_EVENT_STATUS,
    input wire [15:0] KEYBOARD_EVENT_STATUS,
    input wire [15:0] PIN_EVENT_STATUS_LOW,
    input wire [15:0] DEBUG_SERIAL_EVENT_STATUS
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST || RTC_RST);

    sequence s_pin_read;
        READ_STROBE && ADDRESS == `SLIS_PIN_STATUS_OFF;
    endsequence

    a_unused_zero: assert property (
        (AUDIO_EVENT_STATUS & ~`SLIS_AUD_FLAG_BITS) == 16'h0000 &&
        (KEYBOARD_EVENT_STATUS & ~`SLIS_KEY_FLAG_BITS) == 16'h0000 &&
        (DEBUG_SERIAL_EVENT_STATUS & 16'hF0FE) == 16'h0000) else $error("unused status bit set");
    a_dbg_bit_one: assert property (DEBUG_SERIAL_EVENT_STATUS[0]) else $error("debug bit 0 low");
    a_mic_overrun: assert property (
        MIC_SAMPLE_STROBE && MIC_HOLDING_VALID |=> AUDIO_EVENT_STATUS[9]) else $error("overrun missed");
    a_overrun_cause: assert property ($rose(AUDIO_EVENT_STATUS[9]) |->
        $past(MIC_SAMPLE_STROBE) && $past(MIC_HOLDING_VALID)) else $error("overrun without cause");
    a_mic_rx_done: assert property (
        MIC_SAMPLE_STROBE |=> AUDIO_EVENT_STATUS[8]) else $error("receive flag missed");
    a_spk_underrun: assert property (
        SPK_DA_XFER_STROBE && !SPK_HOLDING_VALID |=> AUDIO_EVENT_STATUS[1]) else $error("underrun missed");
    a_pin_event: assert property (PIN_EVENTS != 16'h0000 |=>
        (PIN_EVENT_STATUS_LOW & $past(PIN_EVENTS)) == $past(PIN_EVENTS)) else $error("pin flag missed");
    a_pin_read: assert property (
        s_pin_read |=> READ_DATA == $past(PIN_EVENT_STATUS_LOW)) else $error("pin word read wrong");
    a_pin_summary: assert property (
        PIN_GROUP_SUMMARY |-> PIN_EVENT_STATUS_LOW != 16'h0000) else $error("summary without flag");
endmodule // slis_checker

bind slis_status slis_checker slis_checker_i (.*);

//--- verification/slis_periph.sv
// peripheral units that raise and clear events toward the status block
// assumes the bench calls fire and set_cts from its sequence
`timescale 1ns/1ps

module slis_periph (
    input  wire        CLOCK,
    output wire        MIC_PAGE2_EVENT,
    output wire        MIC_PAGE1_EVENT,
    output wire        MIC_SAMPLE_STROBE,
    output wire        MIC_HOLDING_VALID,
    output wire        SPK_PAGE2_EVENT,
    output wire        SPK_PAGE1_EVENT,
    output wire        SPK_DA_XFER_STROBE,
    output wire        SPK_HOLDING_VALID,
    output wire [15:0] AUDIO_CLEAR,
    output wire        KEY_SCAN_LOST_EVENT,
    output wire        KEY_SCAN_DONE_EVENT,
    output wire        KEY_PRESS_EVENT,
    output wire [15:0] KEYBOARD_CLEAR,
    output wire [15:0] PIN_EVENTS,
    output wire [15:0] PIN_CLEAR,
    output wire        DEBUG_CLEAR_TO_SEND_N,
    output wire        DBG_RX_ERROR_EVENT,
    output wire        DBG_RX_DONE_EVENT,
    output wire        DBG_TX_DONE_EVENT,
    output wire [15:0] DEBUG_CLEAR
);
    logic [15:0] ev_reg [4] = '{default: 16'h0000};
    logic [15:0] clr_reg [4] = '{default: 16'h0000};
    logic        cts_n_reg = 1'b1;

    // audio word: holding levels ride in bits 9 and 0 so they meet the strobe
    assign MIC_PAGE2_EVENT = ev_reg[0][11];
    assign MIC_PAGE1_EVENT = ev_reg[0][10];
    assign MIC_HOLDING_VALID = ev_reg[0][9];
    assign MIC_SAMPLE_STROBE = ev_reg[0][8];
    assign SPK_PAGE2_EVENT = ev_reg[0][3];
    assign SPK_PAGE1_EVENT = ev_reg[0][2];
    assign SPK_DA_XFER_STROBE = ev_reg[0][1];
    assign SPK_HOLDING_VALID = ev_reg[0][0];
    assign KEY_SCAN_LOST_EVENT = ev_reg[1][2];
    assign KEY_SCAN_DONE_EVENT = ev_reg[1][1];
    assign KEY_PRESS_EVENT = ev_reg[1][0];
    assign PIN_EVENTS = ev_reg[2];
    assign DBG_RX_ERROR_EVENT = ev_reg[3][10];
    assign DBG_RX_DONE_EVENT = ev_reg[3][9];
    assign DBG_TX_DONE_EVENT = ev_reg[3][8];
    assign DEBUG_CLEAR_TO_SEND_N = cts_n_reg;
    assign AUDIO_CLEAR = clr_reg[0];
    assign KEYBOARD_CLEAR = clr_reg[1];
    assign PIN_CLEAR = clr_reg[2];
    assign DEBUG_CLEAR = clr_reg[3];

    // one-cycle pulse of events (c low) or of a clear vector (c high)
    task automatic fire(input int u, input [15:0] v, input bit c);
        @(posedge CLOCK);
        if (c) clr_reg[u] <= v;
        else ev_reg[u] <= v;
        @(posedge CLOCK);
        clr_reg[u] <= 16'h0000;
        ev_reg[u] <= 16'h0000;
    endtask

    // event and clear vectors pulsed in the same cycle
    task automatic fire_both(input int u, input [15:0] s, input [15:0] k);
        @(posedge CLOCK);
        ev_reg[u] <= s;
        clr_reg[u] <= k;
        @(posedge CLOCK);
        ev_reg[u] <= 16'h0000;
        clr_reg[u] <= 16'h0000;
    endtask

    task automatic set_cts(input bit v);
        @(posedge CLOCK);
        cts_n_reg <= v;
    endtask
endmodule // slis_periph

//--- verification/slis_status_tb.sv
// self-checking bench of the event status block
// assumes the peripheral model and checker are compiled alongside
`timescale 1ns/1ps
`include "slis_consts.vh"

module slis_status_tb;
    logic        CLOCK = 1'b0, RST = 1'b1, RTC_RST = 1'b0;
    logic        WRITE_STROBE = 1'b0, READ_STROBE = 1'b0;
    logic [31:0] ADDRESS = 32'h00000000;
    logic [15:0] WRITE_DATA = 16'h0000;
    wire  [15:0] READ_DATA, AUDIO_EVENT_STATUS, KEYBOARD_EVENT_STATUS;
    wire  [15:0] PIN_EVENT_STATUS_LOW, DEBUG_SERIAL_EVENT_STATUS;
    wire  [15:0] AUDIO_CLEAR, KEYBOARD_CLEAR, PIN_EVENTS, PIN_CLEAR, DEBUG_CLEAR;
    wire         MIC_PAGE2_EVENT, MIC_PAGE1_EVENT, MIC_SAMPLE_STROBE, MIC_HOLDING_VALID;
    wire         SPK_PAGE2_EVENT, SPK_PAGE1_EVENT, SPK_DA_XFER_STROBE, SPK_HOLDING_VALID;
    wire         KEY_SCAN_LOST_EVENT, KEY_SCAN_DONE_EVENT, KEY_PRESS_EVENT, DEBUG_CLEAR_TO_SEND_N;
    wire         DBG_RX_ERROR_EVENT, DBG_RX_DONE_EVENT, DBG_TX_DONE_EVENT;
    wire         AUDIO_GROUP_SUMMARY, KEYBOARD_GROUP_SUMMARY, PIN_GROUP_SUMMARY, DEBUG_GROUP_SUMMARY;
    int          error_cnt = 0, num_checks = 0;

    slis_status slis_status_i (.*);
    slis_periph slis_periph_i (.*);

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input [31:0] a, input [15:0] d);
        @(posedge CLOCK);
        ADDRESS <= a;
        WRITE_DATA <= d;
        WRITE_STROBE <= 1'b1;
        @(posedge CLOCK);
        WRITE_STROBE <= 1'b0;
    endtask

    // read data is looked at only in the one cycle it stands
    task automatic rd(input [31:0] a, input [15:0] e);
        @(posedge CLOCK);
        ADDRESS <= a;
        READ_STROBE <= 1'b1;
        @(posedge CLOCK);
        READ_STROBE <= 1'b0;
        @(negedge CLOCK);
        chk(READ_DATA, e);
    endtask

    task automatic ev(input int u, input [15:0] v, input bit c);
        slis_periph_i.fire(u, v, c);
        @(negedge CLOCK);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(`SLIS_AUD_STATUS_OFF, 16'h0000);
        rd(`SLIS_KEY_STATUS_OFF, 16'h0000);
        rd(`SLIS_PIN_STATUS_OFF, 16'h0000);
        rd(`SLIS_DBG_STATUS_OFF, 16'h0001);
        // the answer stands one cycle only
        @(negedge CLOCK);
        chk(READ_DATA, 16'h0000);
        rd(32'h0B0000A0, 16'h0000);
        $display("reset test done");
    endtask

    task automatic t_audio;
        ev(0, 16'h0C0C, 0);
        chk(AUDIO_EVENT_STATUS, 16'h0C0C);
        ev(0, 16'h0100, 0);
        chk(AUDIO_EVENT_STATUS, 16'h0D0C);
        ev(0, 16'h0003, 0);
        chk(AUDIO_EVENT_STATUS, 16'h0D0C);
        ev(0, 16'h0002, 0);
        chk(AUDIO_EVENT_STATUS, 16'h0D0E);
        ev(0, 16'h0300, 0);
        rd(`SLIS_AUD_STATUS_OFF, 16'h0F0E);
        ev(0, 16'h0F0E, 1);
        chk(AUDIO_EVENT_STATUS, 16'h0000);
        wr(`SLIS_AUD_MASK_OFF, 16'hFFFF);
        rd(`SLIS_AUD_MASK_OFF, `SLIS_AUD_FLAG_BITS);
        ev(0, 16'h0400, 0);
        chk({15'h0000, AUDIO_GROUP_SUMMARY}, 16'h0001);
        wr(`SLIS_AUD_MASK_OFF, 16'h0000);
        repeat (2) @(negedge CLOCK);
        chk({15'h0000, AUDIO_GROUP_SUMMARY}, 16'h0000);
        ev(0, 16'h0400, 1);
        $display("audio test done");
    endtask

    task automatic t_keyboard;
        wr(`SLIS_KEY_MASK_OFF, 16'hFFFF);
        rd(`SLIS_KEY_MASK_OFF, `SLIS_KEY_FLAG_BITS);
        for (int i = 0; i < 3; i++) begin
            ev(1, 16'h0001 << i, 0);
            chk(KEYBOARD_EVENT_STATUS, 16'h0001 << i);
            chk({15'h0000, KEYBOARD_GROUP_SUMMARY}, 16'h0001);
            ev(1, 16'h0001 << i, 1);
        end
        $display("keyboard test done");
    endtask

    task automatic t_pins;
        wr(`SLIS_PIN_MASK_OFF, 16'h8001);
        rd(`SLIS_PIN_MASK_OFF, 16'h8001);
        for (int n = 0; n < 16; n++) begin
            ev(2, 16'h0001 << n, 0);
            rd(`SLIS_PIN_STATUS_OFF, 16'h0001 << n);
            chk({15'h0000, PIN_GROUP_SUMMARY}, 16'((n == 0) || (n == 15)));
            ev(2, 16'h0001 << n, 1);
        end
        // event and clear in one cycle: the event wins
        ev(2, 16'h0030, 0);
        slis_periph_i.fire_both(2, 16'h0010, 16'h0030);
        @(negedge CLOCK);
        chk(PIN_EVENT_STATUS_LOW, 16'h0010);
        ev(2, 16'h0010, 1);
        $display("pin test done");
    endtask

    task automatic t_debug;
        wr(`SLIS_DBG_MASK_OFF, 16'hFFFF);
        rd(`SLIS_DBG_MASK_OFF, `SLIS_DBG_FLAG_BITS);
        ev(3, 16'h0700, 0);
        chk(DEBUG_SERIAL_EVENT_STATUS, 16'h0701);
        chk({15'h0000, DEBUG_GROUP_SUMMARY}, 16'h0001);
        slis_periph_i.set_cts(1'b0);
        repeat (6) @(negedge CLOCK);
        chk(DEBUG_SERIAL_EVENT_STATUS, 16'h0F01);
        // status words ignore software writes
        wr(`SLIS_DBG_STATUS_OFF, 16'h0001);
        rd(`SLIS_DBG_STATUS_OFF, 16'h0F01);
        ev(3, 16'hFFFF, 1);
        chk(DEBUG_SERIAL_EVENT_STATUS, 16'h0001);
        slis_periph_i.set_cts(1'b1);
        repeat (6) @(negedge CLOCK);
        ev(3, 16'h0800, 1);
        $display("debug test done");
    endtask

    task automatic t_rtc_reset;
        ev(2, 16'hFFFF, 0);
        chk(PIN_EVENT_STATUS_LOW, 16'hFFFF);
        @(posedge CLOCK);
        RTC_RST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        RTC_RST <= 1'b0;
        @(negedge CLOCK);
        chk(PIN_EVENT_STATUS_LOW, 16'h0000);
        chk({15'h0000, PIN_GROUP_SUMMARY}, 16'h0000);
        chk(DEBUG_SERIAL_EVENT_STATUS, 16'h0001);
        rd(`SLIS_PIN_MASK_OFF, 16'h0000);
        $display("second reset test done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        forever #20 CLOCK = ~CLOCK;
    end

    // whole run is a few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge CLOCK);
        RST <= 1'b0;
        t_reset();
        t_audio();
        t_keyboard();
        t_pins();
        t_debug();
        t_rtc_reset();
        finish_test();
    end
endmodule // slis_status_tb
